// ### bfce_top.sv
// byte-field compare engine: equal/unequal terminating, ascending/descending
// assumes a register file outside that applies the write-back pulse, and a
// byte storage port answering each read with a one-cycle acknowledge
`timescale 1ns/100ps
`default_nettype none
`include "bfce_params.svh"
module bfce_top (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic START,
  input wire logic [`BFCE_GR_WIDTH-1:0] INSTR_WORD,
  input wire bfce_pkg::bfce_word_t INSTR_ADDR,
  input wire bfce_pkg::bfce_word_t STORAGE_LIMIT,
  input wire logic PROBLEM_STATE,
  input wire logic INT_PENDING,
  input wire logic [`BFCE_GR_COUNT*`BFCE_GR_WIDTH-1:0] GR_FILE,
  output logic MEM_RD,
  output bfce_pkg::bfce_word_t MEM_ADDR,
  input wire bfce_pkg::bfce_byte_t MEM_RD_DATA,
  input wire logic MEM_ACK,
  input wire logic MEM_PROT_FAULT,
  output logic BUSY,
  output logic DONE,
  output logic SUSPENDED,
  output logic CHK_INVALID_FUNC,
  output logic CHK_INVALID_ADDR,
  output logic CHK_PROTECT,
  output logic REG_WB,
  output bfce_pkg::bfce_sel_t WB_FIRST_SEL,
  output bfce_pkg::bfce_word_t WB_FIRST_PTR,
  output bfce_pkg::bfce_sel_t WB_SECOND_SEL,
  output bfce_pkg::bfce_word_t WB_SECOND_PTR,
  output bfce_pkg::bfce_word_t WB_COUNT,
  output logic IND_CARRY,
  output logic IND_OVERFLOW,
  output logic IND_EVEN,
  output logic IND_NEGATIVE,
  output logic IND_ZERO
);
  import bfce_pkg::*;

  bfce_state_e state, next_state;
  logic [`BFCE_GR_WIDTH-1:0] instr, next_instr;
  bfce_word_t ptr1, next_ptr1;
  bfce_word_t ptr2, next_ptr2;
  bfce_word_t count, next_count;
  bfce_byte_t byte1, next_byte1;
  bfce_byte_t byte2, next_byte2;
  bfce_flags_s flags, next_flags;
  logic mem_rd, next_mem_rd;
  bfce_word_t mem_addr, next_mem_addr;
  logic done, next_done;
  logic susp, next_susp;
  logic chk_func, next_chk_func;
  logic chk_addr, next_chk_addr;
  logic chk_prot, next_chk_prot;
  logic wb, next_wb;
  logic busy, next_busy;

  bfce_sel_t sel1, sel2, pick1, pick2;
  logic down, unequal_variant, instr_bad, hit;
  bfce_word_t step1, step2, count_less;

  bfce_cmp_if cmp ();

  bfce_byte_alu u_alu (
    .cmp(cmp)
  );

  bfce_addr_step #(.WIDTH(`BFCE_GR_WIDTH)) u_step1 (
    .ptr(ptr1),
    .down(down),
    .stepped(step1)
  );

  bfce_addr_step #(.WIDTH(`BFCE_GR_WIDTH)) u_step2 (
    .ptr(ptr2),
    .down(down),
    .stepped(step2)
  );

  // bit 11 is not decoded at all, so a set bit changes nothing here
  always_comb begin
    pick1 = INSTR_WORD[`BFCE_FLD_R1_HI:`BFCE_FLD_R1_LO];
    pick2 = INSTR_WORD[`BFCE_FLD_R2_HI:`BFCE_FLD_R2_LO];
    sel1 = instr[`BFCE_FLD_R1_HI:`BFCE_FLD_R1_LO];
    sel2 = instr[`BFCE_FLD_R2_HI:`BFCE_FLD_R2_LO];
    down = instr[`BFCE_FLD_DIR];
    unequal_variant = instr[`BFCE_FLD_VARIANT];
    cmp.op1 = byte1;
    cmp.op2 = byte2;
    count_less = count - `BFCE_COUNT_STEP;
    // the one-word instruction must lie wholly inside installed storage
    instr_bad = ({1'b0, INSTR_ADDR} + `BFCE_INSTR_BYTES) > {1'b0, STORAGE_LIMIT};
    hit = unequal_variant ? ~cmp.flags.zero : cmp.flags.zero;
  end

  always_comb begin
    next_state = state;
    next_instr = instr;
    next_ptr1 = ptr1;
    next_ptr2 = ptr2;
    next_count = count;
    next_byte1 = byte1;
    next_byte2 = byte2;
    next_flags = flags;
    next_mem_rd = mem_rd;
    next_mem_addr = mem_addr;
    next_done = 1'b0;
    next_susp = 1'b0;
    next_chk_func = 1'b0;
    next_chk_addr = 1'b0;
    next_chk_prot = 1'b0;
    next_wb = 1'b0;
    unique case (state)
      BFCE_IDLE: begin
        if (START) begin
          next_instr = INSTR_WORD;
          next_ptr1 = GR_FILE[int'(pick1)*`BFCE_GR_WIDTH +: `BFCE_GR_WIDTH];
          next_ptr2 = GR_FILE[int'(pick2)*`BFCE_GR_WIDTH +: `BFCE_GR_WIDTH];
          next_count = GR_FILE[int'(`BFCE_COUNT_REG)*`BFCE_GR_WIDTH +: `BFCE_GR_WIDTH];
          next_state = BFCE_DECODE;
        end
      end
      BFCE_DECODE: begin
        if (sel1 == `BFCE_COUNT_REG || sel2 == `BFCE_COUNT_REG) begin
          next_chk_func = 1'b1;
          next_done = 1'b1;
          next_state = BFCE_IDLE;
        end else if (instr_bad) begin
          next_chk_addr = 1'b1;
          next_done = 1'b1;
          next_state = BFCE_IDLE;
        end else if (count == `BFCE_COUNT_ZERO) begin
          // no write-back and indicators left alone
          next_done = 1'b1;
          next_state = BFCE_IDLE;
        end else begin
          next_state = BFCE_ISSUE1;
        end
      end
      BFCE_ISSUE1: begin
        if (ptr1 > STORAGE_LIMIT) begin
          next_chk_addr = 1'b1;
          next_wb = 1'b1;
          next_done = 1'b1;
          next_state = BFCE_IDLE;
        end else begin
          next_mem_rd = 1'b1;
          next_mem_addr = ptr1;
          next_state = BFCE_WAIT1;
        end
      end
      BFCE_WAIT1: begin
        if (MEM_ACK) begin
          next_mem_rd = 1'b0;
          next_byte1 = MEM_RD_DATA;
          if (MEM_PROT_FAULT && PROBLEM_STATE) begin
            next_chk_prot = 1'b1;
            next_wb = 1'b1;
            next_done = 1'b1;
            next_state = BFCE_IDLE;
          end else begin
            next_state = BFCE_ISSUE2;
          end
        end
      end
      BFCE_ISSUE2: begin
        if (ptr2 > STORAGE_LIMIT) begin
          next_chk_addr = 1'b1;
          next_wb = 1'b1;
          next_done = 1'b1;
          next_state = BFCE_IDLE;
        end else begin
          next_mem_rd = 1'b1;
          next_mem_addr = ptr2;
          next_state = BFCE_WAIT2;
        end
      end
      BFCE_WAIT2: begin
        if (MEM_ACK) begin
          next_mem_rd = 1'b0;
          next_byte2 = MEM_RD_DATA;
          if (MEM_PROT_FAULT && PROBLEM_STATE) begin
            next_chk_prot = 1'b1;
            next_wb = 1'b1;
            next_done = 1'b1;
            next_state = BFCE_IDLE;
          end else begin
            next_state = BFCE_COMPARE;
          end
        end
      end
      BFCE_COMPARE: begin
        next_flags = cmp.flags;
        next_ptr1 = step1;
        next_ptr2 = step2;
        if (hit) begin
          // pointers move past the hit, count keeps this byte
          next_wb = 1'b1;
          next_done = 1'b1;
          next_state = BFCE_IDLE;
        end else begin
          next_count = count_less;
          if (count_less == `BFCE_COUNT_ZERO) begin
            next_wb = 1'b1;
            next_done = 1'b1;
            next_state = BFCE_IDLE;
          end else if (INT_PENDING) begin
            // registers hold the exact progress, so a restart is a fresh start
            next_wb = 1'b1;
            next_susp = 1'b1;
            next_state = BFCE_IDLE;
          end else begin
            next_state = BFCE_ISSUE1;
          end
        end
      end
      default: begin
        next_mem_rd = 1'b0;
        next_state = BFCE_IDLE;
      end
    endcase
    // own flop so the pin carries no gate after the state register
    next_busy = (next_state != BFCE_IDLE);
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state <= BFCE_IDLE;
      instr <= `BFCE_WORD_RESET;
      ptr1 <= `BFCE_WORD_RESET;
      ptr2 <= `BFCE_WORD_RESET;
      count <= `BFCE_WORD_RESET;
      byte1 <= `BFCE_BYTE_RESET;
      byte2 <= `BFCE_BYTE_RESET;
      flags <= '0;
      mem_rd <= 1'b0;
      mem_addr <= `BFCE_WORD_RESET;
      done <= 1'b0;
      susp <= 1'b0;
      chk_func <= 1'b0;
      chk_addr <= 1'b0;
      chk_prot <= 1'b0;
      wb <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      instr <= next_instr;
      ptr1 <= next_ptr1;
      ptr2 <= next_ptr2;
      count <= next_count;
      byte1 <= next_byte1;
      byte2 <= next_byte2;
      flags <= next_flags;
      mem_rd <= next_mem_rd;
      mem_addr <= next_mem_addr;
      done <= next_done;
      susp <= next_susp;
      chk_func <= next_chk_func;
      chk_addr <= next_chk_addr;
      chk_prot <= next_chk_prot;
      wb <= next_wb;
      busy <= next_busy;
    end
  end

  always_comb begin
    MEM_RD = mem_rd;
    MEM_ADDR = mem_addr;
    BUSY = busy;
    DONE = done;
    SUSPENDED = susp;
    CHK_INVALID_FUNC = chk_func;
    CHK_INVALID_ADDR = chk_addr;
    CHK_PROTECT = chk_prot;
    REG_WB = wb;
    WB_FIRST_SEL = sel1;
    WB_FIRST_PTR = ptr1;
    WB_SECOND_SEL = sel2;
    WB_SECOND_PTR = ptr2;
    WB_COUNT = count;
    IND_CARRY = flags.carry;
    IND_OVERFLOW = flags.overflow;
    IND_EVEN = flags.even;
    IND_NEGATIVE = flags.negative;
    IND_ZERO = flags.zero;
  end
endmodule
`default_nettype wire

// ### bfce_params.svh
// constants of the byte-field compare engine: field positions, widths, counts
// assumes nothing; included by its bare name
`ifndef BFCE_PARAMS_SVH
`define BFCE_PARAMS_SVH
`define BFCE_GR_WIDTH 16
`define BFCE_GR_COUNT 8
`define BFCE_SEL_WIDTH 3
`define BFCE_FLD_R1_HI 7
`define BFCE_FLD_R1_LO 5
`define BFCE_FLD_R2_HI 10
`define BFCE_FLD_R2_LO 8
`define BFCE_FLD_RSVD 11
`define BFCE_FLD_VARIANT 12
`define BFCE_FLD_DIR 13
`define BFCE_COUNT_REG 3'h7
`define BFCE_COUNT_ZERO 16'h0000
`define BFCE_COUNT_STEP 16'h0001
`define BFCE_ADDR_STEP 16'h0001
`define BFCE_INSTR_BYTES 17'h00001
`define BFCE_WORD_RESET 16'h0000
`define BFCE_BYTE_RESET 8'h00
`endif

// ### bfce_pkg.sv
// types shared by the byte-field compare engine modules
// assumes bfce_params.svh for the widths
`include "bfce_params.svh"
package bfce_pkg;
  typedef logic [`BFCE_GR_WIDTH-1:0] bfce_word_t;
  typedef logic [7:0] bfce_byte_t;
  typedef logic [`BFCE_SEL_WIDTH-1:0] bfce_sel_t;
  typedef enum logic [7:0] {
    BFCE_IDLE    = 8'h01,
    BFCE_DECODE  = 8'h02,
    BFCE_ISSUE1  = 8'h04,
    BFCE_WAIT1   = 8'h08,
    BFCE_ISSUE2  = 8'h10,
    BFCE_WAIT2   = 8'h20,
    BFCE_COMPARE = 8'h40,
    BFCE_SPARE   = 8'h80
  } bfce_state_e;
  typedef struct packed {
    logic carry;
    logic overflow;
    logic even;
    logic negative;
    logic zero;
  } bfce_flags_s;
endpackage

// ### bfce_cmp_if.sv
// carries a byte pair to the subtractor and its indicator result back
// assumes bfce_pkg is compiled first
`timescale 1ns/100ps
`default_nettype none
interface bfce_cmp_if;
  import bfce_pkg::*;
  bfce_byte_t op1;
  bfce_byte_t op2;
  bfce_flags_s flags;
  modport core (output op1, output op2, input flags);
  modport alu (input op1, input op2, output flags);
endinterface
`default_nettype wire

// ### bfce_byte_alu.sv
// byte subtractor: operand 2 minus operand 1, indicators only
// assumes the caller never stores the difference back to storage
`timescale 1ns/100ps
`default_nettype none
`include "bfce_params.svh"
module bfce_byte_alu (
  bfce_cmp_if.alu cmp
);
  import bfce_pkg::*;
  logic [8:0] diff;
  always_comb begin
    diff = {1'b0, cmp.op2} - {1'b0, cmp.op1};
    cmp.flags.carry = diff[8];
    // signs differ and result sign leaves operand 2's sign: out of -128..127
    cmp.flags.overflow = (cmp.op2[7] != cmp.op1[7]) && (diff[7] != cmp.op2[7]);
    cmp.flags.even = ~diff[0];
    cmp.flags.negative = diff[7];
    cmp.flags.zero = (diff[7:0] == `BFCE_BYTE_RESET);
  end
endmodule
`default_nettype wire

// ### bfce_addr_step.sv
// steps one operand pointer by one byte up or down
// assumes wrap-around at the top of the pointer width
`timescale 1ns/100ps
`default_nettype none
`include "bfce_params.svh"
module bfce_addr_step #(
  parameter int WIDTH = `BFCE_GR_WIDTH
) (
  input wire logic [WIDTH-1:0] ptr,
  input wire logic down,
  output logic [WIDTH-1:0] stepped
);
  // refused at elaboration: the pointer can be neither narrower than 2 bits nor wider than a register
  if (WIDTH < 2 || WIDTH > `BFCE_GR_WIDTH) begin : g_bad_width
    $error("bfce_addr_step: bad WIDTH");
  end
  localparam logic [WIDTH-1:0] ONE = WIDTH'(`BFCE_ADDR_STEP);
  always_comb begin
    stepped = down ? ptr - ONE : ptr + ONE;
  end
endmodule
`default_nettype wire

// ### bfce_top_properties.sv
// port-level assertions for the byte-field compare engine
// assumes it is bound onto bfce_top; one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
`include "bfce_params.svh"
module bfce_top_checker (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic START,
  input wire logic [`BFCE_GR_WIDTH-1:0] INSTR_WORD,
  input wire logic [`BFCE_GR_COUNT*`BFCE_GR_WIDTH-1:0] GR_FILE,
  input wire logic PROBLEM_STATE,
  input wire logic MEM_RD,
  input wire bfce_pkg::bfce_word_t MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic MEM_PROT_FAULT,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic SUSPENDED,
  input wire logic CHK_INVALID_FUNC,
  input wire logic CHK_INVALID_ADDR,
  input wire logic CHK_PROTECT,
  input wire logic REG_WB,
  input wire logic IND_CARRY,
  input wire logic IND_OVERFLOW,
  input wire logic IND_EVEN,
  input wire logic IND_NEGATIVE,
  input wire logic IND_ZERO
);
  import bfce_pkg::*;
  logic take;
  logic r7;
  logic [4:0] flags;
  assign take = START && !BUSY;
  assign r7 = INSTR_WORD[7:5] == `BFCE_COUNT_REG || INSTR_WORD[10:8] == `BFCE_COUNT_REG;
  assign flags = {IND_CARRY, IND_OVERFLOW, IND_EVEN, IND_NEGATIVE, IND_ZERO};
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  rd_hold_a: assert property (MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR))
    else $error("read dropped or moved before its answer");
  one_read_a: assert property (MEM_ACK |=> !MEM_RD)
    else $error("read still up after its answer");
  idle_quiet_a: assert property (!BUSY |-> !MEM_RD)
    else $error("storage read while idle");
  bad_field_a: assert property (take && r7 |-> ##[2:3] DONE && CHK_INVALID_FUNC && !REG_WB)
    else $error("count register as pointer not refused");
  zero_cnt_a: assert property (take && GR_FILE[127:112] == `BFCE_COUNT_ZERO |-> ##[2:3] DONE && !REG_WB)
    else $error("zero count did not act as no-op");
  chk_done_a: assert property (CHK_INVALID_ADDR || CHK_PROTECT |-> DONE && !BUSY)
    else $error("check without termination");
  prot_a: assert property (MEM_ACK && MEM_PROT_FAULT && PROBLEM_STATE |-> ##[1:3] CHK_PROTECT && DONE)
    else $error("protect fault not reported");
  susp_a: assert property (SUSPENDED |-> REG_WB && !DONE && !BUSY)
    else $error("suspend without progress write-back");
  end_a: assert property ($fell(BUSY) |-> DONE || SUSPENDED)
    else $error("operation ended silently");
  flags_idle_a: assert property (!BUSY && !$past(BUSY) |-> $stable(flags))
    else $error("indicators moved while idle");
  cover property (SUSPENDED);
  cover property (DONE && REG_WB);
  cover property (CHK_PROTECT);
endmodule
`default_nettype wire

// ### bfce_storage_model.sv
// byte storage answering the engine's read port
// assumes one outstanding read; no write path, so operands never change
`timescale 1ns/100ps
`default_nettype none
module bfce_storage_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic mem_rd,
  input wire bfce_pkg::bfce_word_t mem_addr,
  input wire logic slow,
  input wire logic fault,
  output logic mem_ack,
  output bfce_pkg::bfce_byte_t mem_rd_data,
  output logic mem_prot_fault
);
  import bfce_pkg::*;
  bfce_byte_t mem [0:255];
  logic [1:0] waited;
  // data toggles when not answering, so a stale sample never matches
  always @(posedge ref_clk) begin
    mem_rd_data <= reset ? 8'h5A : ~mem_rd_data;
    if (reset || !mem_rd || mem_ack) begin
      mem_ack <= 1'h0;
      mem_prot_fault <= 1'h0;
      waited <= 2'h0;
    end else if (waited == 2'h3 || !slow) begin
      mem_ack <= 1'h1;
      mem_rd_data <= mem[mem_addr[7:0]];
      mem_prot_fault <= fault;
    end else begin
      waited <= waited + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### bfce_top_test.sv
// self-checking bench for the byte-field compare engine
// assumes bfce_storage_model on the storage port; inputs change at negedge
`timescale 1ns/100ps
`default_nettype none
`define EQ(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module bfce_top_test;
  import bfce_pkg::*;
  logic clk = 0, rst = 1, start = 0, prob = 0, intp = 0, slow = 0, flt = 0;
  logic [15:0] iw = '0;
  bfce_word_t ia = '0;
  logic [127:0] gr = '0;
  logic mem_rd, ack, pflt, busy, done, susp, cif, cia, cpr, wb;
  bfce_word_t maddr, p1w, p2w, cw;
  bfce_byte_t mdata;
  bfce_sel_t s1w, s2w;
  logic [4:0] flg;
  int num_errors = 0, num_checks = 0;
  bfce_top u_bfce_top (.REF_CLK(clk), .RESET(rst), .START(start), .INSTR_WORD(iw),
    .INSTR_ADDR(ia), .STORAGE_LIMIT(16'h00FF), .PROBLEM_STATE(prob), .INT_PENDING(intp),
    .GR_FILE(gr), .MEM_RD(mem_rd), .MEM_ADDR(maddr), .MEM_RD_DATA(mdata), .MEM_ACK(ack),
    .MEM_PROT_FAULT(pflt), .BUSY(busy), .DONE(done), .SUSPENDED(susp),
    .CHK_INVALID_FUNC(cif), .CHK_INVALID_ADDR(cia), .CHK_PROTECT(cpr), .REG_WB(wb),
    .WB_FIRST_SEL(s1w), .WB_FIRST_PTR(p1w), .WB_SECOND_SEL(s2w), .WB_SECOND_PTR(p2w),
    .WB_COUNT(cw), .IND_CARRY(flg[4]), .IND_OVERFLOW(flg[3]), .IND_EVEN(flg[2]),
    .IND_NEGATIVE(flg[1]), .IND_ZERO(flg[0]));
  bfce_storage_model u_bfce_storage_model (.ref_clk(clk), .reset(rst), .mem_rd(mem_rd),
    .mem_addr(maddr), .slow(slow), .fault(flt), .mem_ack(ack), .mem_rd_data(mdata),
    .mem_prot_fault(pflt));
  initial forever #4 clk = ~clk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [15:0] mk(bit dn, bit ne, bit [2:0] a, bit [2:0] b);
    return {2'h0, dn, ne, 1'h0, b, a, 5'h00};
  endfunction
  task automatic put(input int a, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) u_bfce_storage_model.mem[a + i] = v[8 * i +: 8];
  endtask
  // ctl is {bad instruction address, problem state, fault, interrupt, slow}
  task automatic run(input logic [15:0] w, input bfce_word_t c, a, b, input logic [4:0] ctl);
    int n;
    @(negedge clk);
    {prob, flt, intp, slow} = ctl[3:0];
    ia = ctl[4] ? 16'h00FF : 16'h0000;
    gr = '0;
    gr[16 * w[7:5] +: 16] = a;
    gr[16 * w[10:8] +: 16] = b;
    gr[127:112] = c;
    iw = w;
    start = 1;
    @(negedge clk);
    start = 0;
    for (n = 0; n < 300 && !(done || susp); n++) @(posedge clk) #1;
    if (n == 300) begin
      num_errors++;
      wrap_up();
    end
  endtask
  // st is {done, suspended, write-back, bad function, bad address, protect}
  task automatic chk(input logic [5:0] st, input bfce_word_t a, b, c);
    `EQ({done, susp, wb, cif, cia, cpr}, st)
    if (st[3]) `EQ({p1w, p2w, cw}, {a, b, c})
    $display("test ended at %0t", $time);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) rst = 0;
    put('h10, 32'h00810201, 3);
    put('h40, 32'h00010302, 3);
    run(mk(0, 0, 1, 2), 3, 16'h0010, 16'h0040, 5'h01);
    chk(6'h28, 16'h0013, 16'h0043, 16'h0000);
    `EQ({s1w, s2w}, {3'h1, 3'h2})
    `EQ(flg, 5'h1E)
    put('h40, 32'h01, 1);
    run(mk(1, 0, 3, 4), 5, 16'h0012, 16'h0042, 5'h00);
    chk(6'h28, 16'h000F, 16'h003F, 16'h0003);
    `EQ(flg, 5'h05)
    put('h20, 32'h0000007F, 2);
    put('h50, 32'h0000807F, 2);
    run(mk(0, 1, 0, 6), 4, 16'h0020, 16'h0050, 5'h00);
    chk(6'h28, 16'h0022, 16'h0052, 16'h0003);
    `EQ(flg, 5'h06)
    put('h22, 32'h00, 1);
    run(mk(0, 0, 1, 2), 3, 16'h0020, 16'h0021, 5'h02);
    chk(6'h18, 16'h0021, 16'h0022, 16'h0002);
    `EQ(flg, 5'h12)
    run(mk(0, 0, 1, 2), 2, 16'h0021, 16'h0022, 5'h00);
    chk(6'h28, 16'h0022, 16'h0023, 16'h0002);
    run(mk(0, 0, 1, 2), 0, 16'h0010, 16'h0040, 5'h00);
    chk(6'h20, 16'h0000, 16'h0000, 16'h0000);
    `EQ(flg, 5'h05)
    run(mk(0, 0, 7, 2), 3, 16'h0010, 16'h0040, 5'h00);
    chk(6'h24, 16'h0000, 16'h0000, 16'h0000);
    run(mk(1, 1, 1, 7), 3, 16'h0010, 16'h0040, 5'h00);
    chk(6'h24, 16'h0000, 16'h0000, 16'h0000);
    run(mk(0, 0, 1, 2), 2, 16'h0010, 16'h0040, 5'h10);
    chk(6'h22, 16'h0000, 16'h0000, 16'h0000);
    run(mk(0, 0, 1, 2), 2, 16'h0100, 16'h0040, 5'h00);
    chk(6'h2A, 16'h0100, 16'h0040, 16'h0002);
    run(mk(0, 0, 1, 2), 2, 16'h0010, 16'h0040, 5'h0C);
    chk(6'h29, 16'h0010, 16'h0040, 16'h0002);
    run(mk(1, 1, 1, 2), 2, 16'h0011, 16'h0041, 5'h05);
    chk(6'h28, 16'h0010, 16'h0040, 16'h0002);
    `EQ(flg, 5'h00)
    wrap_up();
  end
endmodule
bind bfce_top bfce_top_checker u_bfce_top_checker (.REF_CLK(REF_CLK), .RESET(RESET),
  .START(START), .INSTR_WORD(INSTR_WORD), .GR_FILE(GR_FILE), .PROBLEM_STATE(PROBLEM_STATE),
  .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_PROT_FAULT(MEM_PROT_FAULT),
  .BUSY(BUSY), .DONE(DONE), .SUSPENDED(SUSPENDED), .CHK_INVALID_FUNC(CHK_INVALID_FUNC),
  .CHK_INVALID_ADDR(CHK_INVALID_ADDR), .CHK_PROTECT(CHK_PROTECT), .REG_WB(REG_WB),
  .IND_CARRY(IND_CARRY), .IND_OVERFLOW(IND_OVERFLOW), .IND_EVEN(IND_EVEN),
  .IND_NEGATIVE(IND_NEGATIVE), .IND_ZERO(IND_ZERO));
`default_nettype wire
